// File: logic/tpm_coh.sv
// One-channel 16-bit timer/PWM core with byte-wide buffered registers.
// Assumes a byte register port on clk_sys_i; debug halt and capture come synchronised.
`timescale 1ns/1ps
module tpm_coh (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        debug_halt_mode_i,
    input  wire logic        capture_pulse_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [2:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    output logic             ch_out_o,
    output logic      [15:0] timer_count_o,
    output logic      [15:0] channel_value_o
);
    logic [7:0]  module_status_control_r;
    logic [7:0]  channel_status_control_r;
    logic [15:0] timer_count_r;
    logic [6:0]  pre_r;
    logic [15:0] modulo_value_r;
    logic [15:0] mod_buf_r;
    logic [1:0]  mod_got_r;
    logic [15:0] channel_value_r;
    logic [15:0] chv_buf_r;
    logic [1:0]  chv_got_r;
    logic        chv_pend_r;
    logic        down_r;
    logic [7:0]  cnt_latch_r;
    logic        cnt_lat_v_r;
    logic [7:0]  chv_latch_r;
    logic        chv_lat_v_r;
    logic        ch_out_r;
    logic [7:0]  rdata_r;

    wire w_sc   = wr_i && addr_i == tpm_coh_pkg::ADDR_SC;
    wire w_cnt  = wr_i && (addr_i == tpm_coh_pkg::ADDR_CNTH ||
                           addr_i == tpm_coh_pkg::ADDR_CNTL);
    wire w_modh = wr_i && addr_i == tpm_coh_pkg::ADDR_MODH;
    wire w_modl = wr_i && addr_i == tpm_coh_pkg::ADDR_MODL;
    wire w_chsc = wr_i && addr_i == tpm_coh_pkg::ADDR_CHSC;
    wire w_chvh = wr_i && addr_i == tpm_coh_pkg::ADDR_CHVH;
    wire w_chvl = wr_i && addr_i == tpm_coh_pkg::ADDR_CHVL;
    wire r_cnth = rd_i && addr_i == tpm_coh_pkg::ADDR_CNTH;
    wire r_cntl = rd_i && addr_i == tpm_coh_pkg::ADDR_CNTL;
    wire r_chvh = rd_i && addr_i == tpm_coh_pkg::ADDR_CHVH;
    wire r_chvl = rd_i && addr_i == tpm_coh_pkg::ADDR_CHVL;
    wire r_cnt_any = r_cnth || r_cntl;
    wire r_chv_any = r_chvh || r_chvl;
    // Halted reads bypass the latches: a debugger must see the frozen value, not half a pair
    wire cnt_use_lat = cnt_lat_v_r && !debug_halt_mode_i;
    wire chv_use_lat = chv_lat_v_r && !debug_halt_mode_i;

    // Second byte of a read pair comes from the latch unless the debugger is looking
    function automatic logic [7:0] coh_byte(input logic       use_lat,
                                            input logic [7:0] lat,
                                            input logic [7:0] live);
        return use_lat ? lat : live;
    endfunction : coh_byte

    // Byte kept for the second read: the one the first read did not return
    function automatic logic [7:0] partner_byte(input logic hi_first, input logic [15:0] v);
        return hi_first ? v[7:0] : v[15:8];
    endfunction : partner_byte

    wire [1:0] clks  = module_status_control_r[tpm_coh_pkg::SC_CLKS_LSB +: 2];
    wire [2:0] ps    = module_status_control_r[tpm_coh_pkg::SC_PS_LSB +: 3];
    wire       cpwm  = module_status_control_r[tpm_coh_pkg::SC_CPWM_BIT];
    tpm_coh_pkg::ch_mode_e ch_mode;
    assign ch_mode = tpm_coh_pkg::ch_mode_e'(
        channel_status_control_r[tpm_coh_pkg::CHSC_MODE_LSB +: 2]);

    // Prescaler terminal count marks one timer tick; frozen in debug halt
    wire running  = clks != 2'b00 && !debug_halt_mode_i;
    wire [6:0] ps_mask = 7'(({7'h00, 1'b1} << ps) - 8'h01);
    wire tick     = running && ((pre_r & ps_mask) == ps_mask);
    wire [15:0] top = (modulo_value_r == 16'h0000) ? tpm_coh_pkg::FREE_TOP
                                                   : modulo_value_r;
    wire [15:0] top_m1 = 16'(top - 16'h0001);
    wire up_step  = tick && !(cpwm && down_r);
    // Counter reaching the top from top-1 is the PWM update point
    wire at_top_step = up_step && timer_count_r == top_m1;

    logic [15:0] cnt_nxt;
    logic        down_nxt;
    always_comb begin
        cnt_nxt  = timer_count_r;
        down_nxt = down_r;
        if (tick) begin
            if (cpwm) begin
                if (!down_r && timer_count_r == top) begin
                    down_nxt = 1'b1;
                    cnt_nxt  = top_m1;
                end else if (down_r && timer_count_r == 16'h0000) begin
                    down_nxt = 1'b0;
                    cnt_nxt  = 16'h0001;
                end else begin
                    cnt_nxt  = down_r ? 16'(timer_count_r - 16'h0001)
                                      : 16'(timer_count_r + 16'h0001);
                end
            end else begin
                cnt_nxt = (timer_count_r == top) ? 16'h0000
                                                 : 16'(timer_count_r + 16'h0001);
            end
        end
    end

    // Channel value transfer point chosen by mode
    wire chv_full = chv_got_r == 2'b11 || chv_pend_r;
    wire in_capture = !cpwm && ch_mode == tpm_coh_pkg::CH_CAPTURE;
    wire chv_load = chv_full && (
        (clks == 2'b00) ||
        (!cpwm && ch_mode == tpm_coh_pkg::CH_COMPARE && tick) ||
        ((cpwm || ch_mode == tpm_coh_pkg::CH_EPWM) && at_top_step));
    // Load at the top keeps a period whole: old value runs out, new starts fresh

    // Center PWM compare; value at or past top-1 keeps output active
    wire cpwm_act = (channel_value_r != 16'h0000) &&
                    ((channel_value_r >= top_m1) ||
                     (timer_count_r < channel_value_r));
    wire epwm_act = timer_count_r < channel_value_r;
    logic out_nxt;
    always_comb begin
        out_nxt = ch_out_r;
        if (cpwm)
            out_nxt = cpwm_act;
        else if (ch_mode == tpm_coh_pkg::CH_EPWM)
            out_nxt = epwm_act;
        else if (ch_mode == tpm_coh_pkg::CH_COMPARE && tick &&
                 timer_count_r == channel_value_r)
            out_nxt = !ch_out_r;
    end

    wire clr_cnt_lat = debug_halt_mode_i && (w_sc || w_cnt);
    wire clr_chv_lat = debug_halt_mode_i && w_chsc;
    wire clr_mod_coh = debug_halt_mode_i && w_sc;

    // Read mux: halted reads see live values, latches bypassed
    logic [7:0] rd_nxt;
    always_comb begin
        case (addr_i)
            tpm_coh_pkg::ADDR_SC:   rd_nxt = module_status_control_r;
            tpm_coh_pkg::ADDR_CNTH: rd_nxt = coh_byte(cnt_use_lat, cnt_latch_r,
                                                      timer_count_r[15:8]);
            tpm_coh_pkg::ADDR_CNTL: rd_nxt = coh_byte(cnt_use_lat, cnt_latch_r,
                                                      timer_count_r[7:0]);
            tpm_coh_pkg::ADDR_MODH: rd_nxt = modulo_value_r[15:8];
            tpm_coh_pkg::ADDR_MODL: rd_nxt = modulo_value_r[7:0];
            tpm_coh_pkg::ADDR_CHSC: rd_nxt = channel_status_control_r;
            tpm_coh_pkg::ADDR_CHVH: rd_nxt = coh_byte(chv_use_lat, chv_latch_r,
                                                      channel_value_r[15:8]);
            tpm_coh_pkg::ADDR_CHVL: rd_nxt = coh_byte(chv_use_lat, chv_latch_r,
                                                      channel_value_r[7:0]);
            default:                rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            module_status_control_r  <= tpm_coh_pkg::SC_RST;
            channel_status_control_r <= tpm_coh_pkg::CHSC_RST;
            timer_count_r <= tpm_coh_pkg::CNT_RST;
            pre_r         <= 7'h00;
            down_r        <= 1'b0;
        end else begin
            if (w_sc)
                module_status_control_r <= wdata_i;
            if (w_chsc)
                channel_status_control_r <= wdata_i;
            if (w_cnt) begin
                timer_count_r <= tpm_coh_pkg::CNT_RST;
                pre_r         <= 7'h00;
                down_r        <= 1'b0;
            end else begin
                timer_count_r <= cnt_nxt;
                down_r        <= down_nxt;
                if (running)
                    pre_r <= tick ? 7'h00 : 7'(pre_r + 7'h01);
            end
        end
    end

    // Modulo: both bytes buffered, transfer once the pair is complete
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            modulo_value_r <= tpm_coh_pkg::MOD_RST;
            mod_buf_r      <= tpm_coh_pkg::MOD_RST;
            mod_got_r      <= 2'b00;
        end else if (clr_mod_coh) begin
            mod_got_r <= 2'b00;
        end else begin
            if (w_modh)
                mod_buf_r[15:8] <= wdata_i;
            if (w_modl)
                mod_buf_r[7:0] <= wdata_i;
            if (mod_got_r == 2'b11) begin
                modulo_value_r <= mod_buf_r;
                mod_got_r      <= 2'b00;
            end else begin
                mod_got_r <= mod_got_r | {w_modh, w_modl};
            end
        end
    end

    // Channel value: capture beats buffered software writes
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            channel_value_r <= tpm_coh_pkg::CHV_RST;
            chv_buf_r       <= tpm_coh_pkg::CHV_RST;
            chv_got_r       <= 2'b00;
            chv_pend_r      <= 1'b0;
        end else if (in_capture) begin
            chv_got_r  <= 2'b00;
            chv_pend_r <= 1'b0;
            if (capture_pulse_i)
                channel_value_r <= timer_count_r;
        end else if (w_sc) begin
            chv_got_r  <= 2'b00;
        end else begin
            if (w_chvh)
                chv_buf_r[15:8] <= wdata_i;
            if (w_chvl)
                chv_buf_r[7:0] <= wdata_i;
            if (chv_load) begin
                channel_value_r <= chv_buf_r;
                chv_pend_r      <= 1'b0;
                chv_got_r       <= 2'b00;
            end else if ((chv_got_r | {w_chvh, w_chvl}) == 2'b11) begin
                chv_pend_r <= 1'b1;
                chv_got_r  <= 2'b00;
            end else begin
                chv_got_r <= chv_got_r | {w_chvh, w_chvl};
            end
        end
    end

    // Output level and read data; rdata holds until the next read
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ch_out_r <= 1'b0;
            rdata_r  <= 8'h00;
        end else begin
            ch_out_r <= out_nxt;
            if (rd_i)
                rdata_r <= rd_nxt;
        end
    end

    // Counter read latch; first byte read captures the partner byte
    // A counter write also drops the latch, so a stale half pair never survives a reload
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cnt_latch_r <= 8'h00;
            cnt_lat_v_r <= 1'b0;
        end else if (clr_cnt_lat || w_cnt) begin
            cnt_lat_v_r <= 1'b0;
        end else if (r_cnt_any && !debug_halt_mode_i) begin
            cnt_lat_v_r <= !cnt_lat_v_r;
            if (!cnt_lat_v_r)
                cnt_latch_r <= partner_byte(r_cnth, timer_count_r);
        end
    end

    // Channel value read latch, same pairing as the counter
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            chv_latch_r <= 8'h00;
            chv_lat_v_r <= 1'b0;
        end else if (clr_chv_lat) begin
            chv_lat_v_r <= 1'b0;
        end else if (r_chv_any && !debug_halt_mode_i) begin
            chv_lat_v_r <= !chv_lat_v_r;
            if (!chv_lat_v_r)
                chv_latch_r <= partner_byte(r_chvh, channel_value_r);
        end
    end

    assign rdata_o         = rdata_r;
    assign ch_out_o        = ch_out_r;
    assign timer_count_o   = timer_count_r;
    assign channel_value_o = channel_value_r;
endmodule : tpm_coh

// File: common/tpm_coh_pkg.sv
// Constants for the timer/PWM buffering and coherency block.
// Assumes a byte-wide register port driven by logic on the same clock.
package tpm_coh_pkg;
    localparam int          CNT_W        = 16;
    localparam int          PRE_W        = 7;
    localparam logic [15:0] FREE_TOP     = 16'hFFFF;
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam logic [15:0] MOD_RST      = 16'h0000;
    localparam logic [15:0] CHV_RST      = 16'h0000;
    localparam logic [2:0]  ADDR_SC      = 3'h0;
    localparam logic [2:0]  ADDR_CNTH    = 3'h1;
    localparam logic [2:0]  ADDR_CNTL    = 3'h2;
    localparam logic [2:0]  ADDR_MODH    = 3'h3;
    localparam logic [2:0]  ADDR_MODL    = 3'h4;
    localparam logic [2:0]  ADDR_CHSC    = 3'h5;
    localparam logic [2:0]  ADDR_CHVH    = 3'h6;
    localparam logic [2:0]  ADDR_CHVL    = 3'h7;
    localparam int          SC_CPWM_BIT  = 5;
    localparam int          SC_CLKS_LSB  = 3;
    localparam int          SC_PS_LSB    = 0;
    localparam int          CHSC_MODE_LSB = 2;
    localparam logic [7:0]  SC_RST       = 8'h00;
    localparam logic [7:0]  CHSC_RST     = 8'h00;

    typedef enum logic [1:0] {
        CH_CAPTURE = 2'b00,
        CH_COMPARE = 2'b01,
        CH_EPWM    = 2'b10,
        CH_OFF     = 2'b11
    } ch_mode_e;
endpackage : tpm_coh_pkg

// File: test/tpm_coh_asserts.sv
// Concurrent checks on the ports of the timer/PWM coherency block.
// Assumes one clock, synchronous active-low reset, and both modulo bytes written together.
`timescale 1ns/1ps
module tpm_coh_asserts (
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    input wire logic        debug_halt_mode_i,
    input wire logic        capture_pulse_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [2:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        ch_out_o,
    input wire logic [15:0] timer_count_o,
    input wire logic [15:0] channel_value_o
);
    logic [7:0]  sc_r;
    logic [7:0]  chsc_r;
    logic [15:0] mod_r;
    // Modulo pairing is not mirrored: a half-written modulo would skew top_w
    wire  [15:0] top_w = (mod_r == tpm_coh_pkg::MOD_RST) ? tpm_coh_pkg::FREE_TOP : mod_r;
    wire         clk_on_w = (sc_r[4:3] != 2'b00);
    wire         cap_w = !sc_r[5] && (chsc_r[3:2] == 2'b00);
    wire         pwm_w = clk_on_w && (sc_r[5] || chsc_r[3:2] == 2'b10);
    wire         cmp_w = clk_on_w && !sc_r[5] && (chsc_r[3:2] == 2'b01);
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            sc_r   <= tpm_coh_pkg::SC_RST;
            chsc_r <= tpm_coh_pkg::CHSC_RST;
            mod_r  <= tpm_coh_pkg::MOD_RST;
        end else if (wr_i) begin
            if (addr_i == tpm_coh_pkg::ADDR_SC) sc_r <= wdata_i;
            if (addr_i == tpm_coh_pkg::ADDR_CHSC) chsc_r <= wdata_i;
            if (addr_i == tpm_coh_pkg::ADDR_MODH) mod_r[15:8] <= wdata_i;
            if (addr_i == tpm_coh_pkg::ADDR_MODL) mod_r[7:0] <= wdata_i;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    AST_CNT_CLEAR: assert property (
        wr_i && (addr_i == tpm_coh_pkg::ADDR_CNTH || addr_i == tpm_coh_pkg::ADDR_CNTL)
        |-> ##[1:2] timer_count_o == tpm_coh_pkg::CNT_RST) else $error("count not cleared");
    AST_HALT_FREEZE: assert property (
        debug_halt_mode_i && $past(debug_halt_mode_i) && $past(debug_halt_mode_i, 2)
        && !$past(wr_i) && !$past(wr_i, 2) |-> $stable(timer_count_o)) else $error("count moved");
    AST_HALT_CNT_RD: assert property (
        debug_halt_mode_i && $past(debug_halt_mode_i, 2) && !$past(wr_i) && rd_i
        && (addr_i == tpm_coh_pkg::ADDR_CNTH || addr_i == tpm_coh_pkg::ADDR_CNTL)
        |=> rdata_o == (($past(addr_i) == tpm_coh_pkg::ADDR_CNTH) ? $past(timer_count_o[15:8])
        : $past(timer_count_o[7:0]))) else $error("halted count read not live");
    AST_HALT_CHV_RD: assert property (
        debug_halt_mode_i && $past(debug_halt_mode_i, 2) && !$past(wr_i) && rd_i
        && (addr_i == tpm_coh_pkg::ADDR_CHVH || addr_i == tpm_coh_pkg::ADDR_CHVL)
        |=> rdata_o == (($past(addr_i) == tpm_coh_pkg::ADDR_CHVH) ? $past(channel_value_o[15:8])
        : $past(channel_value_o[7:0]))) else $error("halted value read not actual");
    AST_CAPTURE_HOLD: assert property (
        cap_w && $past(cap_w) && $past(cap_w, 2) && !$past(capture_pulse_i)
        && !$past(capture_pulse_i, 2) |-> $stable(channel_value_o)) else $error("value written");
    AST_PWM_LOAD_TOP: assert property (
        pwm_w && $past(pwm_w) && $past(pwm_w, 2) && $changed(channel_value_o)
        |-> timer_count_o == top_w || $past(timer_count_o) == top_w
        || $past(timer_count_o, 2) == top_w) else $error("value loaded away from top");
    AST_CMP_LOAD_TICK: assert property (
        cmp_w && $past(cmp_w) && $past(cmp_w, 2) && $changed(channel_value_o)
        |-> timer_count_o != $past(timer_count_o)
        || $past(timer_count_o) != $past(timer_count_o, 2)) else $error("load off tick");
    AST_CPWM_FULL: assert property (
        pwm_w && sc_r[5] && $past(pwm_w, 3) && channel_value_o != tpm_coh_pkg::CHV_RST
        && channel_value_o >= top_w - 16'h0001 && $past(channel_value_o, 3) == channel_value_o
        && $stable(channel_value_o) |-> ch_out_o) else $error("full duty not active");
endmodule : tpm_coh_asserts
bind tpm_coh tpm_coh_asserts tpm_coh_asserts_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .debug_halt_mode_i(debug_halt_mode_i), .capture_pulse_i(capture_pulse_i), .wr_i(wr_i),
    .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ch_out_o(ch_out_o),
    .timer_count_o(timer_count_o), .channel_value_o(channel_value_o));

// File: test/tpm_coh_tb_top.sv
// Directed self-checking bench for the timer/PWM coherency block.
// Assumes the checker is bound by its own file; inputs move on falling edges.
`timescale 1ns/1ps
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module tpm_coh_tb_top;
    logic        clk_sys_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        debug_halt_mode_i = 1'b0;
    logic        capture_pulse_i = 1'b0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [2:0]  addr_i = 3'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic [7:0]  rdata_o;
    logic        ch_out_o;
    logic [15:0] timer_count_o;
    logic [15:0] channel_value_o;
    logic [7:0]  rb;
    int          error_cnt = 0;
    int          tests_run = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    tpm_coh tpm_coh_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .debug_halt_mode_i(debug_halt_mode_i), .capture_pulse_i(capture_pulse_i), .wr_i(wr_i),
        .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ch_out_o(ch_out_o),
        .timer_count_o(timer_count_o), .channel_value_o(channel_value_o));
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(negedge clk_sys_i);
        wr_i = 1'b0;
    endtask : wr
    task automatic wr16(input logic [2:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 3'h1, v[7:0]);
    endtask : wr16
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        rd_i = 1'b1;
        addr_i = a;
        @(negedge clk_sys_i);
        rd_i = 1'b0;
        @(negedge clk_sys_i);
        d = rdata_o;
    endtask : rd
    // Polls at falling edges so the counter has settled; bounded so a stuck count ends the run
    task automatic wait_cnt(input logic [15:0] v);
        int n = 0;
        while (timer_count_o !== v && n < 2000) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 2000) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t count wait timed out", $time);
            end_of_test();
        end
    endtask : wait_cnt
    task automatic t_capture;
        `CHK(timer_count_o, tpm_coh_pkg::CNT_RST, "count after reset");
        `CHK(ch_out_o, 1'b0, "output after reset");
        wr(tpm_coh_pkg::ADDR_CHSC, 8'h00);
        wr16(tpm_coh_pkg::ADDR_CHVH, 16'h5AA5);
        cyc(4);
        `CHK(channel_value_o, tpm_coh_pkg::CHV_RST, "capture mode took a write");
        @(negedge clk_sys_i);
        capture_pulse_i = 1'b1;
        @(negedge clk_sys_i);
        capture_pulse_i = 1'b0;
        cyc(3);
        `CHK(channel_value_o, 16'h0000, "captured value");
        $display("test capture done");
    endtask : t_capture
    task automatic t_compare;
        wr(tpm_coh_pkg::ADDR_SC, 8'h0F);
        wr(tpm_coh_pkg::ADDR_CHSC, 8'h04);
        wr(tpm_coh_pkg::ADDR_CNTL, 8'h00);
        wr16(tpm_coh_pkg::ADDR_CHVH, 16'h1234);
        cyc(40);
        `CHK(timer_count_o, 16'h0000, "prescaler not cleared");
        `CHK(channel_value_o, 16'h0000, "value loaded before tick");
        cyc(120);
        `CHK(channel_value_o, 16'h1234, "value not loaded at tick");
        $display("test compare done");
    endtask : t_compare
    task automatic t_count_read;
        wr(tpm_coh_pkg::ADDR_CNTH, 8'h00);
        cyc(444);
        rd(tpm_coh_pkg::ADDR_CNTH, rb);
        `CHK(rb, 8'h00, "count high byte");
        cyc(150);
        rd(tpm_coh_pkg::ADDR_CNTL, rb);
        `CHK(rb, 8'h03, "count low byte not latched");
        rd(tpm_coh_pkg::ADDR_CNTH, rb);
        cyc(100);
        debug_halt_mode_i = 1'b1;
        cyc(2);
        rd(tpm_coh_pkg::ADDR_CNTL, rb);
        `CHK(rb, 8'h05, "halted read gave stale byte");
        cyc(300);
        `CHK(timer_count_o, 16'h0005, "count ran in halt");
        rd(tpm_coh_pkg::ADDR_CHVL, rb);
        `CHK(rb, 8'h34, "halted value low byte");
        rd(tpm_coh_pkg::ADDR_CHVH, rb);
        `CHK(rb, 8'h12, "halted value high byte");
        debug_halt_mode_i = 1'b0;
        $display("test count read done");
    endtask : t_count_read
    task automatic t_epwm;
        wr(tpm_coh_pkg::ADDR_SC, 8'h08);
        wr16(tpm_coh_pkg::ADDR_MODH, 16'h0040);
        wr(tpm_coh_pkg::ADDR_CHSC, 8'h08);
        wr(tpm_coh_pkg::ADDR_CHVH, 8'h00);
        cyc(150);
        `CHK(channel_value_o, 16'h1234, "single byte was transferred");
        wait_cnt(16'h0002);
        wr(tpm_coh_pkg::ADDR_CHVL, 8'h20);
        wait_cnt(16'h003E);
        `CHK(channel_value_o, 16'h1234, "value loaded before top");
        cyc(6);
        `CHK(channel_value_o, 16'h0020, "value not loaded at top");
        wait_cnt(16'h0010);
        cyc(2);
        `CHK(ch_out_o, 1'b1, "edge output low below value");
        wait_cnt(16'h0030);
        cyc(2);
        `CHK(ch_out_o, 1'b0, "edge output high above value");
        $display("test edge pwm done");
    endtask : t_epwm
    // Modulo stays 0x0040, so one centre period is 128 cycles
    task automatic t_steady(input logic [15:0] v, input logic e);
        logic bad = 1'b0;
        wr16(tpm_coh_pkg::ADDR_CHVH, v);
        cyc(300);
        `CHK(channel_value_o, v, "centre value not loaded");
        repeat (130) begin
            @(negedge clk_sys_i);
            if (ch_out_o !== e) bad = 1'b1;
        end
        `CHK(bad, 1'b0, "centre output not steady");
    endtask : t_steady
    // Half pairs left before halt must be dropped by the halted control writes
    task automatic t_halt_clear;
        wr(tpm_coh_pkg::ADDR_CNTL, 8'h00);
        rd(tpm_coh_pkg::ADDR_CNTH, rb);
        rd(tpm_coh_pkg::ADDR_CHVH, rb);
        cyc(20);
        debug_halt_mode_i = 1'b1;
        cyc(2);
        wr(tpm_coh_pkg::ADDR_MODH, 8'h00);
        wr(tpm_coh_pkg::ADDR_SC, 8'h20);
        wr(tpm_coh_pkg::ADDR_MODL, 8'h20);
        wr(tpm_coh_pkg::ADDR_CHSC, 8'h04);
        wr16(tpm_coh_pkg::ADDR_CHVH, 16'h0055);
        cyc(4);
        debug_halt_mode_i = 1'b0;
        rd(tpm_coh_pkg::ADDR_MODL, rb);
        `CHK(rb, 8'h40, "modulo pairing survived halt");
        rd(tpm_coh_pkg::ADDR_CNTL, rb);
        `CHK(rb, timer_count_o[7:0], "count latch survived halt");
        rd(tpm_coh_pkg::ADDR_CHVL, rb);
        `CHK(rb, 8'h55, "value latch survived halt");
        $display("test halt clear done");
    endtask : t_halt_clear
    initial begin
        repeat (8) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        t_capture();
        t_compare();
        t_count_read();
        t_epwm();
        wr(tpm_coh_pkg::ADDR_SC, 8'h28);
        t_steady(16'h0040, 1'b1);
        t_steady(16'h003F, 1'b1);
        t_steady(16'h0000, 1'b0);
        $display("test centre pwm done");
        t_halt_clear();
        end_of_test();
    end
endmodule : tpm_coh_tb_top
